// *** logic/cbtl_pkg.sv ***
/*
  Shared constants and types for the CAN bit timing block: register map,
  field positions, reset values and the segment state encoding.
  Assumes a 32-bit AHB-Lite register bus and a single system clock.
*/
`default_nettype none

package cbtl_pkg;

  // Register byte offsets
  localparam logic [7:0] CBTL_OFS_CONFIG = 8'h00;
  localparam logic [7:0] CBTL_OFS_STATUS = 8'h04;

  // Field positions in the configuration word
  localparam int CBTL_F_PRESC_LSB = 0;
  localparam int CBTL_F_PROP_LSB  = 8;
  localparam int CBTL_F_PH1_LSB   = 12;
  localparam int CBTL_F_PH2_LSB   = 16;
  localparam int CBTL_F_SJW_LSB   = 20;
  localparam int CBTL_F_TRIPLE    = 24;
  localparam int CBTL_F_ENABLE    = 31;

  // Writable bits of the configuration word
  localparam logic [31:0] CBTL_CONFIG_MASK  = 32'h8137_773F;
  localparam logic [31:0] CBTL_CONFIG_RESET = 32'h0000_0000;

  // Field widths
  localparam int CBTL_PRESC_W = 6;
  localparam int CBTL_SEG_W   = 3;
  localparam int CBTL_SJW_W   = 2;
  localparam int CBTL_CNT_W   = 5;

  // AHB encodings
  localparam logic [1:0] CBTL_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CBTL_HTRANS_SEQ    = 2'h3;

  typedef enum logic [3:0] {
    CBTL_SYNC = 4'h1,
    CBTL_PROP = 4'h2,
    CBTL_PH1  = 4'h4,
    CBTL_PH2  = 4'h8
  } cbtl_seg_t;

  typedef struct packed {
    logic                    enable;
    logic                    triple;
    logic [CBTL_SJW_W-1:0]   sjw;
    logic [CBTL_SEG_W-1:0]   ph2;
    logic [CBTL_SEG_W-1:0]   ph1;
    logic [CBTL_SEG_W-1:0]   prop;
    logic [CBTL_PRESC_W-1:0] presc;
  } cbtl_cfg_t;

  typedef struct packed {
    logic        rx_bit;       // Last decided bit value
    logic        sample_pulse; // One cycle after each sample point
    logic        bit_start;    // One cycle at start of each bit but the first after enable
    logic        tq_tick;      // One cycle per time quantum
  } cbtl_out_t;

endpackage : cbtl_pkg

`default_nettype wire

// *** logic/cbtl_top.sv ***
/*
  CAN bit timing: prescaled time quantum, four-segment nominal bit,
  sample point with optional three-sample vote, edge resynchronisation.
  Assumes can_rx comes straight from a transceiver pin (asynchronous) and
  that software reaches the registers as the only AHB-Lite slave.
*/
// Notes on behaviour
// - Quantum equals two times prescaler-plus-one clocks
// - Bit length programmable four to twenty-five quanta
// - Every bit opens with one-quantum sync segment
// - Propagation segment one to eight quanta
// - Phase one segment one to eight quanta
// - Phase two segment one to eight quanta
// - Resync lengthens phase one or shortens two
// - Bit decided when phase one ends
// - Optional majority of three half-quantum-spaced samples
`timescale 1ns/1ps
`default_nettype none

module cbtl_top (
  input  wire logic        hclk,         // System clock, 250 MHz
  input  wire logic        hresetn,      // Asynchronous reset, active low
  input  wire logic        hsel,         // Slave select
  input  wire logic [31:0] haddr,        // Byte address
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write when high
  input  wire logic [2:0]  hsize,        // Transfer size, word only
  input  wire logic [31:0] hwdata,       // Write data
  input  wire logic        hready,       // Bus ready in
  output logic      [31:0] hrdata,       // Read data
  output logic             hreadyout,    // Slave ready
  output logic             hresp,        // Always OKAY
  input  wire logic        can_rx,       // Bus level from transceiver
  output logic             rx_bit,       // Decided received bit
  output logic             sample_pulse, // Pulse after each sample point
  output logic             bit_start,    // Pulse at each sync segment entered from phase two
  output logic             tq_tick       // Pulse per time quantum
);

  typedef struct packed {
    cbtl_pkg::cbtl_cfg_t              cfg;
    logic [31:0]                      rdata;
    logic                             wr_pend;
    logic [7:0]                       wr_addr;
    logic                             rx_meta;
    logic                             rx_sync;
    logic                             rx_prev;
    logic [cbtl_pkg::CBTL_PRESC_W-1:0] div_cnt;
    logic                             half;
    logic [1:0]                       samp_sh;
    cbtl_pkg::cbtl_seg_t              seg;
    logic [cbtl_pkg::CBTL_CNT_W-1:0]  seg_cnt;
    logic [cbtl_pkg::CBTL_CNT_W-1:0]  bit_q;
    logic [cbtl_pkg::CBTL_CNT_W-1:0]  ext;
    logic [cbtl_pkg::CBTL_CNT_W-1:0]  shrink;
    logic                             edge_pend;
    logic                             resync_used;
    cbtl_pkg::cbtl_out_t              out;
  } cbtl_state_t;

  cbtl_state_t st_ff;
  cbtl_state_t nxt_st;

  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction : majority3

  function automatic logic [cbtl_pkg::CBTL_CNT_W-1:0] seg_len(input logic [cbtl_pkg::CBTL_SEG_W-1:0] f);
    seg_len = {2'h0, f} + 5'h01;
  endfunction : seg_len

  logic                            half_tick;
  logic                            q_tick;
  logic                            edge_now;
  logic                            edge_any;
  logic [cbtl_pkg::CBTL_CNT_W-1:0] sjw_q;
  logic [cbtl_pkg::CBTL_CNT_W-1:0] ph1_len;
  logic [cbtl_pkg::CBTL_CNT_W-1:0] ph2_len;
  logic [cbtl_pkg::CBTL_CNT_W-1:0] cur_len;
  logic [cbtl_pkg::CBTL_CNT_W-1:0] ph2_left;
  logic                            seg_end;
  logic                            addr_ok;

  always_comb begin
    nxt_st = st_ff;
    // Quantum is two halves of prescaler+1 clocks; halves feed the vote
    half_tick = st_ff.cfg.enable && (st_ff.div_cnt == st_ff.cfg.presc);
    q_tick    = half_tick && st_ff.half;
    edge_now  = st_ff.rx_prev && !st_ff.rx_sync;
    edge_any  = edge_now || st_ff.edge_pend;
    sjw_q     = {3'h0, st_ff.cfg.sjw} + 5'h01;
    ph1_len   = seg_len(st_ff.cfg.ph1) + st_ff.ext;
    ph2_len   = seg_len(st_ff.cfg.ph2) - st_ff.shrink;
    ph2_left  = ph2_len - st_ff.seg_cnt - 5'h01;
    cur_len   = 5'h01;
    case (st_ff.seg)
      cbtl_pkg::CBTL_SYNC: cur_len = 5'h01;
      cbtl_pkg::CBTL_PROP: cur_len = seg_len(st_ff.cfg.prop);
      cbtl_pkg::CBTL_PH1:  cur_len = ph1_len;
      cbtl_pkg::CBTL_PH2:  cur_len = ph2_len;
      default:             cur_len = 5'h01;
    endcase
    // At or past the end, so a length cut under a running count cannot run away
    seg_end = (st_ff.seg_cnt >= cur_len - 5'h01);

    // Pin passes two flops before anything looks at it
    nxt_st.rx_meta = can_rx;
    nxt_st.rx_sync = st_ff.rx_meta;
    nxt_st.rx_prev = st_ff.rx_sync;

    nxt_st.out.tq_tick      = q_tick;
    nxt_st.out.sample_pulse = 1'b0;
    nxt_st.out.bit_start    = 1'b0;

    // A falling edge seen only after a recessive bit; the clear on a quantum tick beats a new edge
    if (edge_now && st_ff.out.rx_bit) begin
      nxt_st.edge_pend = 1'b1;
    end

    if (!st_ff.cfg.enable) begin
      nxt_st.div_cnt     = '0;
      nxt_st.half        = 1'b0;
      nxt_st.seg         = cbtl_pkg::CBTL_SYNC;
      nxt_st.seg_cnt     = '0;
      nxt_st.bit_q       = '0;
      nxt_st.ext         = '0;
      nxt_st.shrink      = '0;
      nxt_st.edge_pend   = 1'b0;
      nxt_st.resync_used = 1'b0;
    end else if (half_tick) begin
      nxt_st.div_cnt = '0;
      nxt_st.half    = !st_ff.half;
      nxt_st.samp_sh = {st_ff.samp_sh[0], st_ff.rx_sync};
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 6'h01;
    end

    if (q_tick) begin
      nxt_st.edge_pend = 1'b0;
      nxt_st.seg_cnt   = st_ff.seg_cnt + 5'h01;
      nxt_st.bit_q     = st_ff.bit_q + 5'h01;
      if (edge_any && st_ff.out.rx_bit && !st_ff.resync_used) begin
        nxt_st.resync_used = 1'b1;
        if (st_ff.seg == cbtl_pkg::CBTL_PROP || st_ff.seg == cbtl_pkg::CBTL_PH1) begin
          // Late edge: stretch phase one by the error, capped at the jump width
          nxt_st.ext = (st_ff.bit_q < sjw_q) ? st_ff.bit_q : sjw_q;
        end else if (st_ff.seg == cbtl_pkg::CBTL_PH2) begin
          nxt_st.shrink = (ph2_left < sjw_q) ? ph2_left : sjw_q;
        end else begin
          nxt_st.resync_used = st_ff.resync_used;
        end
      end
      if (seg_end || (st_ff.seg == cbtl_pkg::CBTL_PH2 && edge_any && st_ff.out.rx_bit &&
                      !st_ff.resync_used && ph2_left <= sjw_q)) begin
        nxt_st.seg_cnt = '0;
        case (st_ff.seg)
          cbtl_pkg::CBTL_SYNC: nxt_st.seg = cbtl_pkg::CBTL_PROP;
          cbtl_pkg::CBTL_PROP: nxt_st.seg = cbtl_pkg::CBTL_PH1;
          cbtl_pkg::CBTL_PH1: begin
            nxt_st.seg              = cbtl_pkg::CBTL_PH2;
            nxt_st.out.sample_pulse = 1'b1;
            nxt_st.out.rx_bit       = st_ff.cfg.triple ?
                                      majority3(st_ff.samp_sh[1], st_ff.samp_sh[0], st_ff.rx_sync) :
                                      st_ff.rx_sync;
          end
          default: begin
            nxt_st.seg           = cbtl_pkg::CBTL_SYNC;
            nxt_st.bit_q         = '0;
            nxt_st.ext           = '0;
            nxt_st.shrink        = '0;
            nxt_st.resync_used   = 1'b0;
            nxt_st.out.bit_start = 1'b1;
          end
        endcase
      end
    end

    // AHB-Lite: reads sampled in the address phase, writes land in the data phase
    addr_ok = (haddr[7:0] == cbtl_pkg::CBTL_OFS_CONFIG) || (haddr[7:0] == cbtl_pkg::CBTL_OFS_STATUS);
    nxt_st.wr_pend = 1'b0;
    if (st_ff.wr_pend && st_ff.wr_addr == cbtl_pkg::CBTL_OFS_CONFIG) begin
      nxt_st.cfg.presc  = hwdata[cbtl_pkg::CBTL_F_PRESC_LSB +: cbtl_pkg::CBTL_PRESC_W];
      nxt_st.cfg.prop   = hwdata[cbtl_pkg::CBTL_F_PROP_LSB +: cbtl_pkg::CBTL_SEG_W];
      nxt_st.cfg.ph1    = hwdata[cbtl_pkg::CBTL_F_PH1_LSB +: cbtl_pkg::CBTL_SEG_W];
      nxt_st.cfg.ph2    = hwdata[cbtl_pkg::CBTL_F_PH2_LSB +: cbtl_pkg::CBTL_SEG_W];
      nxt_st.cfg.sjw    = hwdata[cbtl_pkg::CBTL_F_SJW_LSB +: cbtl_pkg::CBTL_SJW_W];
      nxt_st.cfg.triple = hwdata[cbtl_pkg::CBTL_F_TRIPLE];
      nxt_st.cfg.enable = hwdata[cbtl_pkg::CBTL_F_ENABLE];
    end
    if (hsel && hready && (htrans == cbtl_pkg::CBTL_HTRANS_NONSEQ || htrans == cbtl_pkg::CBTL_HTRANS_SEQ)) begin
      nxt_st.wr_pend = hwrite && addr_ok;
      nxt_st.wr_addr = haddr[7:0];
      nxt_st.rdata   = '0;
      if (!hwrite && haddr[7:0] == cbtl_pkg::CBTL_OFS_CONFIG) begin
        nxt_st.rdata[cbtl_pkg::CBTL_F_PRESC_LSB +: cbtl_pkg::CBTL_PRESC_W] = st_ff.cfg.presc;
        nxt_st.rdata[cbtl_pkg::CBTL_F_PROP_LSB +: cbtl_pkg::CBTL_SEG_W]    = st_ff.cfg.prop;
        nxt_st.rdata[cbtl_pkg::CBTL_F_PH1_LSB +: cbtl_pkg::CBTL_SEG_W]     = st_ff.cfg.ph1;
        nxt_st.rdata[cbtl_pkg::CBTL_F_PH2_LSB +: cbtl_pkg::CBTL_SEG_W]     = st_ff.cfg.ph2;
        nxt_st.rdata[cbtl_pkg::CBTL_F_SJW_LSB +: cbtl_pkg::CBTL_SJW_W]     = st_ff.cfg.sjw;
        nxt_st.rdata[cbtl_pkg::CBTL_F_TRIPLE]                              = st_ff.cfg.triple;
        nxt_st.rdata[cbtl_pkg::CBTL_F_ENABLE]                              = st_ff.cfg.enable;
      end else if (!hwrite && haddr[7:0] == cbtl_pkg::CBTL_OFS_STATUS) begin
        nxt_st.rdata = {19'h00000, st_ff.bit_q, st_ff.seg, 2'h0, st_ff.rx_sync, st_ff.out.rx_bit};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff         <= '0;
      st_ff.cfg     <= '0;
      st_ff.seg     <= cbtl_pkg::CBTL_SYNC;
      st_ff.rx_meta <= 1'b1;
      st_ff.rx_sync <= 1'b1;
      st_ff.rx_prev <= 1'b1;
      st_ff.samp_sh <= 2'h3;
      st_ff.out     <= cbtl_pkg::cbtl_out_t'(4'h8);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata       = st_ff.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign rx_bit       = st_ff.out.rx_bit;
  assign sample_pulse = st_ff.out.sample_pulse;
  assign bit_start    = st_ff.out.bit_start;
  assign tq_tick      = st_ff.out.tq_tick;

  // Checks; helper counter measures clocks between quantum ticks
  logic [7:0] clk_since_ff;
  logic       tick_seen_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_since_ff <= 8'h00;
      tick_seen_ff <= 1'b0;
    end else if (st_ff.wr_pend || !st_ff.cfg.enable) begin
      clk_since_ff <= 8'h00;
      tick_seen_ff <= 1'b0;
    end else if (q_tick) begin
      clk_since_ff <= 8'h01;
      tick_seen_ff <= 1'b1;
    end else begin
      clk_since_ff <= clk_since_ff + 8'h01;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TQ_PERIOD: assert property (q_tick && tick_seen_ff && !st_ff.wr_pend |->
    clk_since_ff == ({2'h0, st_ff.cfg.presc} + 8'h01) * 8'h02) else $error("quantum period wrong");
  AST_SYNC_ONE: assert property (q_tick && st_ff.seg == cbtl_pkg::CBTL_SYNC |=>
    st_ff.seg == cbtl_pkg::CBTL_PROP && st_ff.seg_cnt == 5'h00) else $error("sync not one quantum");
  AST_PROP_END: assert property (q_tick && st_ff.seg == cbtl_pkg::CBTL_PROP &&
    st_ff.seg_cnt == seg_len(st_ff.cfg.prop) - 5'h01 |=> st_ff.seg == cbtl_pkg::CBTL_PH1)
    else $error("propagation length wrong");
  AST_SAMPLE_AT_PH1: assert property (sample_pulse |-> $past(st_ff.seg) == cbtl_pkg::CBTL_PH1 &&
    st_ff.seg == cbtl_pkg::CBTL_PH2) else $error("sample not at end of phase one");
  AST_PH2_END: assert property (q_tick && st_ff.seg == cbtl_pkg::CBTL_PH2 && seg_end |=>
    st_ff.seg == cbtl_pkg::CBTL_SYNC ##0 bit_start) else $error("phase two end wrong");
  AST_SINGLE_SAMPLE: assert property (sample_pulse && !st_ff.cfg.triple |->
    rx_bit == $past(st_ff.rx_sync)) else $error("single sample mismatch");
  AST_TRIPLE_VOTE: assert property (sample_pulse && st_ff.cfg.triple |->
    rx_bit == majority3($past(st_ff.samp_sh[1]), $past(st_ff.samp_sh[0]), $past(st_ff.rx_sync)))
    else $error("majority vote mismatch");
  AST_JUMP_LIMIT: assert property (st_ff.ext <= sjw_q && st_ff.shrink <= sjw_q)
    else $error("resync exceeds jump width");
  AST_BIT_RESTART: assert property (bit_start |-> st_ff.bit_q == 5'h00 &&
    $past(st_ff.seg) == cbtl_pkg::CBTL_PH2) else $error("quantum count not restarted");
  AST_BIT_RANGE: assert property (st_ff.bit_q < 5'h1D)
    else $error("bit longer than programmable span plus jump");

endmodule : cbtl_top

`default_nettype wire

// *** sim/cbtl_bus_node.sv ***
/*
  Model of the other nodes on the CAN bus, seen through the transceiver.
  Assumes the bench sets the level they hold and may ask for a short
  inverted spike; recessive (1) is the pulled-up idle level.
*/
`timescale 1ns/1ps
`default_nettype none

module cbtl_bus_node (
  input  wire logic       hclk,     // System clock
  input  wire logic       hresetn,  // Reset, active low
  input  wire logic       level,    // Level the other nodes hold
  input  wire logic       flip_req, // Start an inverted spike
  input  wire logic [3:0] flip_len, // Spike length in clocks
  output logic            can_rx    // Bus level at the receiver
);
  logic [3:0] flip_cnt_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) flip_cnt_ff <= 4'h0;
    else if (flip_req) flip_cnt_ff <= flip_len;
    else if (flip_cnt_ff != 4'h0) flip_cnt_ff <= flip_cnt_ff - 4'h1;
  end

  // Nobody drives in reset, so the pull-up wins
  assign can_rx = !hresetn ? 1'b1 : (level ^ (flip_cnt_ff != 4'h0));
endmodule : cbtl_bus_node

`default_nettype wire

// *** sim/cbtl_tb_top.sv ***
/*
  Self-checking bench for the CAN bit timing block: registers over
  AHB-Lite, segment lengths, sample decision, vote and resync.
  Assumes cbtl_top and cbtl_bus_node are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module cbtl_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        can_rx;
  logic        rx_bit;
  logic        sample_pulse;
  logic        bit_start;
  logic        tq_tick;
  logic        level = 1'b1;
  logic        flip_req = 1'b0;
  int          cyc = 0;
  int          fail_count = 0;
  int          n_tests = 0;
  localparam logic [31:0] CFG = {24'h0, cbtl_pkg::CBTL_OFS_CONFIG};
  localparam logic [31:0] STS = {24'h0, cbtl_pkg::CBTL_OFS_STATUS};

  always #2 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  cbtl_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
                .hrdata, .hreadyout, .hresp, .can_rx, .rx_bit, .sample_pulse, .bit_start, .tq_tick);
  cbtl_bus_node node (.hclk, .hresetn, .level, .flip_req, .flip_len(4'h7), .can_rx);

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (i++ > 100) begin
        fail_count++;
        close_out;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // Address phase held until hready, then data phase until hready again
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= cbtl_pkg::CBTL_HTRANS_NONSEQ;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask : ahb

  // Event 0 quantum tick, 1 bit start, 2 sample pulse
  task automatic wait_ev(input int w, output int t);
    int i;
    for (i = 0; i < 5000; i++) begin
      @(posedge hclk);
      #1;
      if ((w == 0 && tq_tick === 1'b1) || (w == 1 && bit_start === 1'b1) || (w == 2 && sample_pulse === 1'b1))
        break;
    end
    t = cyc;
    if (i == 5000) begin
      fail_count++;
      close_out;
    end
  endtask : wait_ev

  // Spike centred on the next sample point, 224 clocks per bit here
  task automatic spike(input logic e, input string nm);
    int t;
    wait_ev(2, t);
    repeat (217) @(posedge hclk);
    flip_req <= 1'b1;
    @(posedge hclk);
    flip_req <= 1'b0;
    wait_ev(2, t);
    chk(nm, {31'h0, e}, {31'h0, rx_bit});
  endtask : spike

  task automatic resync(input int d, input int exp, input string nm);
    int t0;
    int t1;
    wait_ev(1, t0);
    repeat (d) @(posedge hclk);
    level <= 1'b0;
    wait_ev(1, t1);
    chk(nm, 32'(exp), 32'(t1 - t0));
    level <= 1'b1;
    repeat (3) wait_ev(1, t0);
  endtask : resync

  initial begin
    logic [31:0] q;
    logic [31:0] tab [3];
    int t0, t1, t2, tq, p, pr, a, b;
    // Shortest bit, longest bit and an uneven mix
    tab = '{32'h8000_0000, 32'h8007_7701, 32'h8001_3202};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, CFG, 32'h0, q);
    chk("config reset", cbtl_pkg::CBTL_CONFIG_RESET, q);
    ahb(1'b0, STS, 32'h0, q);
    chk("status reset", 32'h0000_0013, q);
    ahb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, q);
    ahb(1'b0, 32'h0000_0008, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    ahb(1'b1, CFG, cbtl_pkg::CBTL_CONFIG_MASK, q);
    ahb(1'b0, CFG, 32'h0, q);
    chk("writable bits", cbtl_pkg::CBTL_CONFIG_MASK, q);
    ahb(1'b1, CFG, ~cbtl_pkg::CBTL_CONFIG_MASK, q);
    ahb(1'b0, CFG, 32'h0, q);
    chk("reserved bits", 32'h0, q);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      p  = int'(tab[k][5:0]);
      pr = int'(tab[k][10:8]);
      a  = int'(tab[k][14:12]);
      b  = int'(tab[k][18:16]);
      tq = 2 * (p + 1);
      ahb(1'b1, CFG, tab[k], q);
      ahb(1'b0, CFG, 32'h0, q);
      chk("config readback", tab[k], q);
      wait_ev(0, t0);
      wait_ev(0, t1);
      chk("quantum", 32'(tq), 32'(t1 - t0));
      wait_ev(1, t0);
      wait_ev(2, t1);
      wait_ev(1, t2);
      chk("bit length", 32'((4 + pr + a + b) * tq), 32'(t2 - t0));
      chk("sync to sample", 32'((3 + pr + a) * tq), 32'(t1 - t0));
      chk("phase two", 32'((b + 1) * tq), 32'(t2 - t1));
      ahb(1'b1, CFG, 32'h0, q);
    end
    $display("test segments done");
    // Fourteen quanta of 16 clocks, sample point at eleven
    ahb(1'b1, CFG, 32'h8002_5307, q);
    level <= 1'b0;
    repeat (2) wait_ev(2, t0);
    chk("dominant decided", 32'h0, {31'h0, rx_bit});
    spike(1'b1, "single sample spike");
    ahb(1'b1, CFG, 32'h8102_5307, q);
    repeat (2) wait_ev(2, t0);
    spike(1'b0, "three sample vote");
    ahb(1'b1, CFG, 32'h0, q);
    $display("test sampling done");
    // Eleven quanta of 4 clocks, jump width one quantum
    level <= 1'b1;
    ahb(1'b1, CFG, 32'h8003_3101, q);
    repeat (3) wait_ev(1, t0);
    resync(16, 48, "phase one lengthened");
    resync(30, 40, "phase two shortened");
    // Jump width of two quanta caps a four-quantum error at two
    ahb(1'b1, CFG, 32'h8013_3101, q);
    repeat (3) wait_ev(1, t0);
    resync(16, 52, "phase one jump capped");
    $display("test resync done");
    close_out;
  end
endmodule : cbtl_tb_top

`default_nettype wire
